// ==== hsr_pkg.sv ====
// Constants, offsets and types of the harvester status register bank
//
// Contract
// R1: Interface-ready interrupt enable is set after reset, no host setup needed.
// R2: Host waits for the interrupt pin high before any serial transfer.
// R3: Writing 1 to load bit sets sync-in-progress while configuration copies.
// R4: Sync-in-progress clears once the copy completes and both copies agree; the code clears it after the eighth word with no compare.
// R5: Load bit 0 selects pin configuration, 1 selects serial configuration.
// R6: Control register 8 bits, flag register 6 bits, both reset to zero.
// R7: A flag sets only while its enable bit is 1.
// R8: Power-monitor-done flag (bit 5) sets when a new result arrives.
// R9: Temperature flag (bit 4) sets when cold or hot threshold is crossed.
// R10: Source-low flag (bit 3) sets when source crosses the sleep threshold.
// R11: Overcharge flag (bit 2) sets when battery crosses overcharge threshold.
// R12: Overdischarge flag (bit 1) sets when battery crosses overdischarge threshold.
// R13: Interface-ready flag (bit 0) sets when the serial interface is ready.
// R14: Status bit 6 reads 1 while charging is active, else 0.
// R15: Status bit 4 reads 1 while temperature is outside the window.
// R16: Status bit 3 reads 0 while source is above sleep threshold, else 1.
// R17: Status bit 2 reads 1 while battery is above overcharge threshold.
// R18: Status bit 1 reads 1 below overdischarge; status is 8 bits, resets zero.
// R19: Pulse-count mode spreads a 24-bit count over three result bytes.
// R20: Energy mode third byte holds shift exponent high, data 19:16 low.
// R21: Temperature result register holds the thermistor divider ADC code.
// R22: Battery result register holds the 8-bit battery voltage ADC code.
// R23: Mode bit 0 selects pulse counting, 1 selects energy-meter format.
// R24: Enabled interrupt conditions are signalled on a dedicated interrupt pin.
// R25: Reading the flag register clears all flags; pin follows enabled flags.
// R26: Sync-in-progress is read-only and the copy ends in bounded cycles.
package hsr_pkg;
   // ======================================================
   // Serial port
   localparam logic [6:0] DEV_ADDR = 7'h2A; // Arbitrary bus address
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // ======================================================
   // Register offsets
   localparam logic [7:0] OFS_INTERRUPT_ENABLES = 8'h09;
   localparam logic [7:0] OFS_CTRL = 8'h0A;
   localparam logic [7:0] OFS_FLAGS = 8'h0B;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_RES0 = 8'h0D;
   localparam logic [7:0] OFS_RES1 = 8'h0E;
   localparam logic [7:0] OFS_RES2 = 8'h0F;
   localparam logic [7:0] OFS_TEMP = 8'h10;
   localparam logic [7:0] OFS_BATT = 8'h11;
   // ======================================================
   // Field positions
   localparam int CTRL_LOAD = 0;
   localparam int CTRL_BUSY = 2;
   localparam int FLG_READY = 0;
   localparam int FLG_UNDER = 1;
   localparam int FLG_OVER = 2;
   localparam int FLG_SRC = 3;
   localparam int FLG_TEMP = 4;
   localparam int FLG_PM = 5;
   localparam int ST_UNDER = 1;
   localparam int ST_OVER = 2;
   localparam int ST_SRC = 3;
   localparam int ST_TEMP = 4;
   localparam int ST_CHARGE = 6;
   // ======================================================
   // Reset values and copy length
   localparam logic [5:0] INTERRUPT_ENABLES_RST = 6'h01;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] CFG_LAST = 3'h7; // Eight configuration words
   // ======================================================
   // Serial engine states
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_AACK = 3'b010,
      L_RX = 3'b011,
      L_WACK = 3'b100,
      L_TX = 3'b101,
      L_RACK = 3'b110
   } hsr_lstate_t;
endpackage : hsr_pkg

// ==== hsr_sync2.sv ====
// Two-flop synchroniser for levels and toggles
module hsr_sync2 #(
   parameter int W = 1
) (
   // Destination clock and source level
   input wire logic clk,
   input wire logic [W-1:0] d,
   // Synchronised level
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] hold_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      meta_q <= d;
      hold_q <= meta_q;
   end
   assign q = hold_q;
endmodule : hsr_sync2

// ==== hsr_cfg_copy.sv ====
// Sequencer copying serial configuration words into the controller
module hsr_cfg_copy (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cen,
   // Start request
   input wire logic start,
   // Copy progress
   output logic sync_in_progress,
   output logic copyStrobe,
   output logic [2:0] copyIndex
);
   logic busy_q;
   logic stb_q;
   logic [2:0] idx_q;
   logic [2:0] cnt_q;
   logic [3:0] busyCycles_q;

   // Walk every word once; a new start restarts the walk
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         busy_q <= 1'b0;
         stb_q <= 1'b0;
         idx_q <= 3'h0;
         cnt_q <= 3'h0;
      end else if (cen) begin
         stb_q <= 1'b0;
         if (start) begin
            busy_q <= 1'b1; // R3
            cnt_q <= 3'h0;
         end else if (busy_q) begin
            stb_q <= 1'b1;
            idx_q <= cnt_q;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == hsr_pkg::CFG_LAST) begin
               busy_q <= 1'b0; // R4
            end
         end
      end
   end
   assign sync_in_progress = busy_q;
   assign copyStrobe = stb_q;
   assign copyIndex = idx_q;

   // Helper count of enabled busy cycles
   always_ff @(posedge sys_clk) begin
      if (!nrst || !busy_q || start) begin
         busyCycles_q <= 4'h0;
      end else if (cen) begin
         busyCycles_q <= busyCycles_q + 4'h1;
      end
   end

   a_busy_bound: assert property (@(posedge sys_clk) disable iff (!nrst) // R26
      busyCycles_q <= 4'h9) else $error("copy busy too long");
   a_copy_walk: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
      (busy_q && cen && !start && cnt_q == 3'h7) |=> !busy_q && copyIndex == 3'h7)
      else $error("copy did not end on last word");
endmodule : hsr_cfg_copy

// ==== hsr_status_regs.sv ====
// Serial register port, interrupt flags and status of the harvester
module hsr_status_regs (
   // System clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cen,
   // Serial link
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Monitor levels
   input wire logic chargeActive,
   input wire logic tempOutside,
   input wire logic srcLow,
   input wire logic batOver,
   input wire logic batUnder,
   // Power monitor results
   input wire logic pmDone,
   input wire logic pmMode,
   input wire logic [23:0] pmCount,
   input wire logic [3:0] pmShift,
   // ADC results
   input wire logic tempValid,
   input wire logic [7:0] tempCode,
   input wire logic batValid,
   input wire logic [7:0] batCode,
   // Interrupt and configuration
   output logic irqPin,
   output logic useSerialCfg,
   output logic cfgCopy,
   output logic [2:0] cfgIndex
);
   // ======================================================
   // Link domain
   logic linkRstN;
   logic sclS;
   logic sdaS;
   logic ackTogS;
   logic ackTog_q;
   logic sclP_q;
   logic sdaP_q;
   logic ackTogP_q;
   logic linkUp_q;
   logic [7:0] rdByte_q;
   logic [7:0] rdData_q;
   hsr_pkg::hsr_lstate_t st_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic [7:0] ptr_q;
   logic first_q;
   logic rw_q;
   logic sdaOe_q;
   logic wrTog_q;
   logic [7:0] wrAddr_q;
   logic [7:0] wrData_q;
   logic rdTog_q;
   logic [7:0] rdAddr_q;
   logic sclRise;
   logic sclFall;
   logic startC;
   logic stopC;

   // Reset enters the link domain through its own synchroniser
   hsr_sync2 #(.W(1)) uRstSync (
      .clk(linkClk),
      .d(nrst),
      .q(linkRstN)
   );

   // Pins and the answer toggle are oversampled on the link clock
   hsr_sync2 #(.W(3)) uLinkSync (
      .clk(linkClk),
      .d({sclIn, sdaIn, ackTog_q}),
      .q({sclS, sdaS, ackTogS})
   );

   // Previous samples for edge, start and stop detection
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         ackTogP_q <= 1'b0;
         linkUp_q <= 1'b0;
      end else begin
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         ackTogP_q <= ackTogS;
         linkUp_q <= 1'b1; // Port can take transfers from here on
      end
   end

   assign sclRise = sclS & ~sclP_q;
   assign sclFall = ~sclS & sclP_q;
   assign startC = sclS & sclP_q & sdaP_q & ~sdaS;
   assign stopC = sclS & sclP_q & ~sdaP_q & sdaS;

   // Read answer is stable when its toggle arrives
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         rdByte_q <= hsr_pkg::BYTE_RST;
      end else if (ackTogS != ackTogP_q) begin
         rdByte_q <= rdData_q;
      end
   end

   // Byte engine; read data is fetched during the ack bit, so
   // the host must keep each clock phase above about 1 us
   always_ff @(posedge linkClk) begin
      if (!linkRstN) begin
         st_q <= hsr_pkg::L_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         ptr_q <= 8'h00;
         first_q <= 1'b0;
         rw_q <= 1'b0;
         sdaOe_q <= 1'b0;
         wrTog_q <= 1'b0;
         wrAddr_q <= 8'h00;
         wrData_q <= 8'h00;
         rdTog_q <= 1'b0;
         rdAddr_q <= 8'h00;
      end else if (stopC) begin
         st_q <= hsr_pkg::L_IDLE;
         sdaOe_q <= 1'b0;
      end else if (startC) begin
         st_q <= hsr_pkg::L_ADDR;
         cnt_q <= 4'h0;
         sdaOe_q <= 1'b0;
      end else begin
         if (sclRise && (st_q == hsr_pkg::L_ADDR || st_q == hsr_pkg::L_RX)) begin
            shift_q <= {shift_q[6:0], sdaS};
            cnt_q <= cnt_q + 4'h1;
         end
         case (st_q)
            hsr_pkg::L_ADDR: begin
               if (sclFall && cnt_q == hsr_pkg::BITS_PER_BYTE) begin
                  if (shift_q[7:1] == hsr_pkg::DEV_ADDR) begin
                     sdaOe_q <= 1'b1;
                     rw_q <= shift_q[0];
                     first_q <= ~shift_q[0];
                     st_q <= hsr_pkg::L_AACK;
                     if (shift_q[0]) begin
                        rdAddr_q <= ptr_q;
                        rdTog_q <= ~rdTog_q;
                     end
                  end else begin
                     st_q <= hsr_pkg::L_IDLE;
                  end
               end
            end
            hsr_pkg::L_AACK: begin
               if (sclFall) begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     shift_q <= rdByte_q;
                     sdaOe_q <= ~rdByte_q[7];
                     st_q <= hsr_pkg::L_TX;
                  end else begin
                     sdaOe_q <= 1'b0;
                     st_q <= hsr_pkg::L_RX;
                  end
               end
            end
            hsr_pkg::L_TX: begin
               if (sclFall) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     sdaOe_q <= 1'b0;
                     st_q <= hsr_pkg::L_RACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sdaOe_q <= ~shift_q[6];
                  end
               end
            end
            hsr_pkg::L_RACK: begin
               if (sclRise) begin
                  if (sdaS) begin
                     st_q <= hsr_pkg::L_IDLE; // Host ends the read
                  end else begin
                     ptr_q <= ptr_q + 8'h01;
                     rdAddr_q <= ptr_q + 8'h01;
                     rdTog_q <= ~rdTog_q;
                  end
               end else if (sclFall) begin
                  cnt_q <= 4'h0;
                  shift_q <= rdByte_q;
                  sdaOe_q <= ~rdByte_q[7];
                  st_q <= hsr_pkg::L_TX;
               end
            end
            hsr_pkg::L_RX: begin
               if (sclFall && cnt_q == hsr_pkg::BITS_PER_BYTE) begin
                  sdaOe_q <= 1'b1;
                  st_q <= hsr_pkg::L_WACK;
                  first_q <= 1'b0;
                  if (first_q) begin
                     ptr_q <= shift_q;
                  end else begin
                     wrAddr_q <= ptr_q;
                     wrData_q <= shift_q;
                     wrTog_q <= ~wrTog_q;
                     ptr_q <= ptr_q + 8'h01;
                  end
               end
            end
            hsr_pkg::L_WACK: begin
               if (sclFall) begin
                  sdaOe_q <= 1'b0;
                  cnt_q <= 4'h0;
                  st_q <= hsr_pkg::L_RX;
               end
            end
            hsr_pkg::L_IDLE: begin
               sdaOe_q <= 1'b0;
            end
            default: begin
               st_q <= hsr_pkg::L_IDLE;
            end
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_q;

   // ======================================================
   // System domain
   logic wrTogS;
   logic rdTogS;
   logic linkUpS;
   logic wrTogP_q;
   logic rdTogP_q;
   logic linkUpP_q;
   logic wrEv;
   logic rdEv;
   logic loadCfg_q;
   logic [5:0] intEn_q;
   logic [5:0] flags_q;
   logic [5:0] flagSet;
   logic flagClr;
   logic [3:0] monP_q;
   logic [7:0] status_q;
   logic [7:0] res0_q;
   logic [7:0] res1_q;
   logic [7:0] res2_q;
   logic [7:0] tempRes_q;
   logic [7:0] batRes_q;
   logic irq_q;
   logic cfgStart;
   logic busy;

   // Link requests arrive as toggles beside stable words
   hsr_sync2 #(.W(3)) uSysSync (
      .clk(sys_clk),
      .d({wrTog_q, rdTog_q, linkUp_q}),
      .q({wrTogS, rdTogS, linkUpS})
   );

   // Toggle history for request events
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wrTogP_q <= 1'b0;
         rdTogP_q <= 1'b0;
         linkUpP_q <= 1'b0;
      end else if (cen) begin
         wrTogP_q <= wrTogS;
         rdTogP_q <= rdTogS;
         linkUpP_q <= linkUpS;
      end
   end

   assign wrEv = cen & (wrTogS ^ wrTogP_q);
   assign rdEv = cen & (rdTogS ^ rdTogP_q);

   // Writable registers; sync-in-progress ignores writes
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         loadCfg_q <= 1'b0; // R6
         intEn_q <= hsr_pkg::INTERRUPT_ENABLES_RST; // R1
      end else if (wrEv) begin
         if (wrAddr_q == hsr_pkg::OFS_CTRL) begin
            loadCfg_q <= wrData_q[hsr_pkg::CTRL_LOAD]; // R5 R26
         end
         if (wrAddr_q == hsr_pkg::OFS_INTERRUPT_ENABLES) begin
            intEn_q <= wrData_q[5:0];
         end
      end
   end

   assign cfgStart = wrEv & (wrAddr_q == hsr_pkg::OFS_CTRL) & wrData_q[hsr_pkg::CTRL_LOAD];

   hsr_cfg_copy uCopy (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .cen(cen),
      .start(cfgStart), // R3
      .sync_in_progress(busy),
      .copyStrobe(cfgCopy),
      .copyIndex(cfgIndex)
   );

   // Monitor crossings in either direction are events
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         monP_q <= 4'h0;
      end else if (cen) begin
         monP_q <= {tempOutside, srcLow, batOver, batUnder};
      end
   end

   always_comb begin
      flagSet = 6'h00;
      flagSet[hsr_pkg::FLG_READY] = linkUpS & ~linkUpP_q; // R13
      flagSet[hsr_pkg::FLG_UNDER] = batUnder ^ monP_q[0]; // R12
      flagSet[hsr_pkg::FLG_OVER] = batOver ^ monP_q[1]; // R11
      flagSet[hsr_pkg::FLG_SRC] = srcLow ^ monP_q[2]; // R10
      flagSet[hsr_pkg::FLG_TEMP] = tempOutside ^ monP_q[3]; // R9
      flagSet[hsr_pkg::FLG_PM] = pmDone; // R8
      flagSet = flagSet & intEn_q & {6{cen}}; // R7
   end

   assign flagClr = rdEv & (rdAddr_q == hsr_pkg::OFS_FLAGS);

   // Sticky flags; a set in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         flags_q <= hsr_pkg::FLAGS_RST; // R6
      end else begin
         flags_q <= (flagClr ? hsr_pkg::FLAGS_RST : flags_q) | flagSet; // R25
      end
   end

   // Interrupt pin follows any enabled flag
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else if (cen) begin
         irq_q <= |(flags_q & intEn_q); // R24 R25
      end
   end
   assign irqPin = irq_q;
   assign useSerialCfg = loadCfg_q;

   // Live status snapshot
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         status_q <= hsr_pkg::BYTE_RST; // R18
      end else if (cen) begin
         status_q <= 8'h00;
         status_q[hsr_pkg::ST_CHARGE] <= chargeActive; // R14
         status_q[hsr_pkg::ST_TEMP] <= tempOutside; // R15
         status_q[hsr_pkg::ST_SRC] <= srcLow; // R16
         status_q[hsr_pkg::ST_OVER] <= batOver; // R17
         status_q[hsr_pkg::ST_UNDER] <= batUnder; // R18
      end
   end

   // Power monitor result bytes in the selected format
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         res0_q <= hsr_pkg::BYTE_RST;
         res1_q <= hsr_pkg::BYTE_RST;
         res2_q <= hsr_pkg::BYTE_RST;
      end else if (cen && pmDone) begin
         res0_q <= pmCount[7:0]; // R19
         res1_q <= pmCount[15:8]; // R19
         if (pmMode) begin
            res2_q <= {pmShift, pmCount[19:16]}; // R20 R23
         end else begin
            res2_q <= pmCount[23:16]; // R19 R23
         end
      end
   end

   // ADC codes are held as delivered
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tempRes_q <= hsr_pkg::BYTE_RST;
         batRes_q <= hsr_pkg::BYTE_RST;
      end else if (cen) begin
         if (tempValid) begin
            tempRes_q <= tempCode; // R21
         end
         if (batValid) begin
            batRes_q <= batCode; // R22
         end
      end
   end

   // Read decode; unmapped offsets read zero
   function automatic logic [7:0] regRead(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         hsr_pkg::OFS_INTERRUPT_ENABLES: v = {2'b00, intEn_q};
         hsr_pkg::OFS_CTRL: v = {5'b00000, busy, 1'b0, loadCfg_q}; // R3 R26
         hsr_pkg::OFS_FLAGS: v = {2'b00, flags_q};
         hsr_pkg::OFS_STATUS: v = status_q;
         hsr_pkg::OFS_RES0: v = res0_q;
         hsr_pkg::OFS_RES1: v = res1_q;
         hsr_pkg::OFS_RES2: v = res2_q;
         hsr_pkg::OFS_TEMP: v = tempRes_q;
         hsr_pkg::OFS_BATT: v = batRes_q;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : regRead

   // Answer each read with data and the toggle in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdData_q <= hsr_pkg::BYTE_RST;
         ackTog_q <= 1'b0;
      end else if (rdEv) begin
         rdData_q <= regRead(rdAddr_q);
         ackTog_q <= ~ackTog_q;
      end
   end

   // ======================================================
   // Checks
   a_en_after_reset: assert property (@(posedge sys_clk) // R1
      $rose(nrst) |-> intEn_q == 6'h01) else $error("ready enable not set");
   a_busy_on_load: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
      cfgStart |-> ##1 busy) else $error("busy missing after load");
   a_cfg_select: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
      (wrEv && wrAddr_q == 8'h0A) |=> useSerialCfg == $past(wrData_q[0]))
      else $error("configuration source wrong");
   a_flag_gated: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
      ((flags_q & ~$past(flags_q) & ~$past(intEn_q)) == 6'h00))
      else $error("flag set while disabled");
   a_pm_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
      (pmDone && cen && intEn_q[5]) |=> flags_q[5]) else $error("done flag missing");
   a_temp_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
      (cen && intEn_q[4] && tempOutside != monP_q[3]) |=> flags_q[4])
      else $error("temperature flag missing");
   a_count_bytes: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
      (pmDone && cen && !pmMode) |=> res0_q == $past(pmCount[7:0])
      && res2_q == $past(pmCount[23:16])) else $error("count bytes wrong");
   a_energy_byte: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
      (pmDone && cen && pmMode) |=> res2_q == {$past(pmShift), $past(pmCount[19:16])})
      else $error("energy byte wrong");
   a_irq_follow: assert property (@(posedge sys_clk) disable iff (!nrst) // R24
      (cen && |(flags_q & intEn_q)) |=> irqPin) else $error("interrupt pin low");
   a_read_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // R25
      (flagClr && flagSet == 6'h00) |=> flags_q == 6'h00) else $error("flags not cleared");
   a_status_src: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
      cen |=> status_q[3] == $past(srcLow)) else $error("source status wrong");

   c_load_seq: cover property (@(posedge sys_clk) disable iff (!nrst)
      cfgStart ##1 busy ##[1:20] !busy);
   c_energy: cover property (@(posedge sys_clk) disable iff (!nrst) pmDone && pmMode);
   c_flag_read: cover property (@(posedge sys_clk) disable iff (!nrst) flagClr && irqPin);
   c_write: cover property (@(posedge sys_clk) disable iff (!nrst) wrEv);
endmodule : hsr_status_regs

// ==== hsr_host_model.sv ====
// Serial host model for the register port of the bank
module hsr_host_model (
   // Bench clock and line level
   input wire logic clk,
   input wire logic sdaLine,
   // Pins driven by the host
   output logic sclOut,
   output logic sdaPull
);
   // ======================================
   // Phases of 20 cycles stay above the 1 us minimum
   localparam int HALF = 20;
   // Idle bus: clock high, data released
   initial begin
      sclOut = 1'b1;
      sdaPull = 1'b0;
   end
   // Wait some cycles
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // Data moves only after the clock fall, so no false start is seen
   task automatic bitx(input logic b, output logic r);
      wt(2);
      sdaPull <= ~b;
      wt(HALF);
      sclOut <= 1'b1;
      wt(HALF);
      r = sdaLine;
      sclOut <= 1'b0;
   endtask : bitx
   // Start or repeated start
   task automatic start();
      wt(2);
      sdaPull <= 1'b0;
      wt(HALF);
      sclOut <= 1'b1;
      wt(HALF);
      sdaPull <= 1'b1;
      wt(HALF);
      sclOut <= 1'b0;
   endtask : start
   // Stop leaves the bus idle
   task automatic stop();
      wt(2);
      sdaPull <= 1'b1;
      wt(HALF);
      sclOut <= 1'b1;
      wt(HALF);
      sdaPull <= 1'b0;
      wt(HALF);
   endtask : stop
   // Byte out, MSB first, then the device acknowledge
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(v[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask : wbyte
   // Byte in, then acknowledge or not
   task automatic rbyte(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         v[i] = r;
      end
      bitx(last, r);
   endtask : rbyte
endmodule : hsr_host_model

// ==== testbench.sv ====
// Self-checking bench of the harvester status register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================
   // Pins, stimulus and counters
   logic sys_clk, nrst, cen, linkClk, sclOut, sdaPull, sdaOe, sdaOut;
   logic strobe, pmMode, irqPin, useSerialCfg, cfgCopy;
   logic [4:0] lv;
   logic [23:0] pmCount;
   logic [3:0] pmShift;
   logic [2:0] cfgIndex;
   wire logic sdaLine;
   int errors = 0;
   int n_checks = 0;
   int nCopy = 0;
   int copyBad = 0;
   // Rows: charge, temp, source, over, under levels; status; flags
   localparam logic [20:0] ROWS [6] = '{{5'h03, 8'h06, 8'h02}, {5'h07, 8'h0E, 8'h08},
      {5'h06, 8'h0C, 8'h02}, {5'h0E, 8'h1C, 8'h10}, {5'h1E, 8'h5C, 8'h00},
      {5'h1C, 8'h58, 8'h04}};
   // Pulled-up data line: low while either side pulls
   assign sdaLine = ~(sdaPull | sdaOe);
   hsr_status_regs uut (.sys_clk(sys_clk), .nrst(nrst), .cen(cen), .linkClk(linkClk),
      .sclIn(sclOut), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chargeActive(lv[4]), .tempOutside(lv[3]), .srcLow(lv[2]), .batOver(lv[1]),
      .batUnder(lv[0]), .pmDone(strobe), .pmMode(pmMode), .pmCount(pmCount),
      .pmShift(pmShift), .tempValid(strobe), .tempCode(pmCount[15:8]), .batValid(strobe),
      .batCode(pmCount[23:16]), .irqPin(irqPin), .useSerialCfg(useSerialCfg),
      .cfgCopy(cfgCopy), .cfgIndex(cfgIndex));
   hsr_host_model host (.clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaPull(sdaPull));
   // Clocks, link one off phase
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      linkClk = 1'b0;
      #17;
      forever #40 linkClk = ~linkClk;
   end
   // Copy pulses must walk the word index up from zero
   always @(posedge sys_clk) begin
      if (cfgCopy === 1'b1) begin
         if (cfgIndex !== nCopy[2:0]) copyBad++;
         nCopy++;
      end
   end
   task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k;
      host.start();
      host.wbyte({hsr_pkg::DEV_ADDR, 1'b0}, k);
      host.wbyte(a, k);
      host.wbyte(d, k);
      host.stop();
   endtask : wr
   // Pointer write, repeated start, one byte read
   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic k;
      logic [7:0] v;
      host.start();
      host.wbyte({hsr_pkg::DEV_ADDR, 1'b0}, k);
      host.wbyte(a, k);
      host.start();
      host.wbyte({hsr_pkg::DEV_ADDR, 1'b1}, k);
      host.rbyte(1'b1, v);
      host.stop();
      check(nm, v, e);
   endtask : rc
   // One result strobe for power, temperature and battery
   task automatic pulse(input logic m);
      @(posedge sys_clk);
      pmMode <= m;
      pmCount <= 24'hA5C3E1;
      pmShift <= 4'h9;
      strobe <= 1'b1;
      @(posedge sys_clk);
      strobe <= 1'b0;
   endtask : pulse
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      {nrst, strobe, pmMode, lv, pmCount, pmShift} = '0;
      cen = 1'b1;
      repeat (6) @(posedge sys_clk);
      check("irq in reset", 8'(irqPin), 8'h00);
      nrst <= 1'b1;
      for (int i = 0; i < 60 && irqPin !== 1'b1; i++) @(posedge sys_clk);
      check("irq ready", 8'(irqPin), 8'h01);
      rc("flags", hsr_pkg::OFS_FLAGS, 8'h01);
      rc("flags clear", hsr_pkg::OFS_FLAGS, 8'h00);
      check("irq clear", 8'(irqPin), 8'h00);
      rc("enables", hsr_pkg::OFS_INTERRUPT_ENABLES, 8'h01);
      rc("control", hsr_pkg::OFS_CTRL, 8'h00);
      rc("status", hsr_pkg::OFS_STATUS, 8'h00);
      lv <= 5'h02;
      rc("masked", hsr_pkg::OFS_FLAGS, 8'h00);
      wr(hsr_pkg::OFS_INTERRUPT_ENABLES, 8'h3F);
      foreach (ROWS[i]) begin
         lv <= ROWS[i][20:16];
         repeat (4) @(posedge sys_clk);
         check("irq", 8'(irqPin), 8'(ROWS[i][7:0] != 8'h00));
         rc("status", hsr_pkg::OFS_STATUS, ROWS[i][15:8]);
         rc("flags", hsr_pkg::OFS_FLAGS, ROWS[i][7:0]);
      end
      pulse(1'b0);
      rc("count low", hsr_pkg::OFS_RES0, 8'hE1);
      rc("count mid", hsr_pkg::OFS_RES1, 8'hC3);
      rc("count high", hsr_pkg::OFS_RES2, 8'hA5);
      rc("done flag", hsr_pkg::OFS_FLAGS, 8'h20);
      rc("temp code", hsr_pkg::OFS_TEMP, 8'hC3);
      rc("bat code", hsr_pkg::OFS_BATT, 8'hA5);
      pulse(1'b1);
      rc("energy high", hsr_pkg::OFS_RES2, 8'h95);
      rc("energy low", hsr_pkg::OFS_RES0, 8'hE1);
      cen <= 1'b0;
      pulse(1'b0);
      cen <= 1'b1;
      rc("frozen", hsr_pkg::OFS_RES2, 8'h95);
      wr(hsr_pkg::OFS_CTRL, 8'h05);
      repeat (20) @(posedge sys_clk);
      check("serial cfg", 8'(useSerialCfg), 8'h01);
      check("copies", 8'(nCopy), 8'h08);
      check("copy order", 8'(copyBad), 8'h00);
      rc("busy done", hsr_pkg::OFS_CTRL, 8'h01);
      wr(hsr_pkg::OFS_CTRL, 8'h00);
      check("pin cfg", 8'(useSerialCfg), 8'h00);
      nrst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      check("reset irq", 8'(irqPin), 8'h00);
      repeat (60) @(posedge sys_clk);
      rc("unmapped", 8'h20, 8'h00);
      end_sim();
   end
   // Watchdog well past the expected 5 ms of traffic
   initial begin
      #8000000;
      errors++;
      end_sim();
   end
endmodule : testbench
